// ---- common/bank_cfg_pkg.sv ----
// constants shared by the per-bank line configuration register block
// assumes a single 100 MHz clock and word-aligned bus accesses
package bank_cfg_pkg;

    // ------------------------------------------------------------
    // register map: printed offsets kept as word indexes
    // ------------------------------------------------------------
    localparam logic [5:0] LOOPBACK_CTRL_LOWER_IDX = 6'h0c;
    localparam logic [5:0] LOSS_CRITERIA_LOWER_IDX = 6'h0d;
    localparam logic [5:0] AUTO_ALL_ONES_LOWER_IDX = 6'h0e;
    localparam logic [5:0] GLOBAL_CONFIG_LOWER_IDX = 6'h0f;
    localparam logic [5:0] LOOPBACK_CTRL_UPPER_IDX = 6'h2c;
    localparam logic [5:0] LOSS_CRITERIA_UPPER_IDX = 6'h2d;
    localparam logic [5:0] AUTO_ALL_ONES_UPPER_IDX = 6'h2e;
    localparam logic [5:0] GLOBAL_CONFIG_UPPER_IDX = 6'h2f;
    // low two index bits pick the register inside a bank
    localparam logic [1:0] SEL_LOOPBACK = 2'h0;
    localparam logic [1:0] SEL_CRITERIA = 2'h1;
    localparam logic [1:0] SEL_ALL_ONES = 2'h2;
    localparam logic [1:0] SEL_GLOBAL = 2'h3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int NUM_REGS = 8;
    localparam int CHANS = 16;
    localparam int BANK_CHANS = 8;

    // ------------------------------------------------------------
    // global configuration field positions
    // ------------------------------------------------------------
    localparam int GC_RX_MATCH_MODE = 7;
    localparam int GC_ALARM_ON_LOSS = 6;
    localparam int GC_PROTECT_DISABLE = 5;
    localparam int GC_LINE_CODE = 4;
    localparam int GC_ATT_DEPTH = 3;
    localparam int GC_CALIBRATE = 2;
    localparam int GC_ATT_POSITION = 1;
    localparam int GC_ATT_ENABLE = 0;

    // ------------------------------------------------------------
    // monitor select decode
    // ------------------------------------------------------------
    localparam int MON_DIR_BIT = 3;
    localparam logic [4:0] MON_CHAN_BASE = 5'h09;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CAL_TIME_NS = 1000;
    localparam int CAL_CYCLES =
        (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : bank_cfg_pkg

// ---- src/monitor_decode.sv ----
// decode of the upper-bank nonintrusive monitor select field
// assumes the caller registers the outputs
`timescale 1ns/1ps
module monitor_decode
    import bank_cfg_pkg::*;
(
    input wire logic [3:0] monitor_select,
    output logic monitor_on,
    output logic monitor_tx,
    output logic [4:0] monitor_chan
);
    always_comb begin
        // zero in the low bits means off, whichever direction
        monitor_on = |monitor_select[2:0];
        monitor_tx = monitor_select[MON_DIR_BIT];
        monitor_chan = monitor_on ?
            MON_CHAN_BASE + {2'h0, monitor_select[2:0]} : 5'h00;
    end
endmodule : monitor_decode

// ---- src/cal_sequencer.sv ----
// receive termination calibration cycle timer
// assumes trigger and enable come from registers on the same clock
`timescale 1ns/1ps
module cal_sequencer
    import bank_cfg_pkg::*;
#(
    parameter int CYCLES = CAL_CYCLES
)(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic trigger,
    input wire logic enable,
    output logic busy
);
    logic trig_q_r;
    logic [15:0] count_r;
    logic start;

    if (CYCLES < 16 || CYCLES > 65535) begin : g_bad_cycles
        $error("cal_sequencer: CYCLES out of range");
    end

    // a rising trigger while idle starts a cycle; retrigger is ignored
    assign start = trigger && !trig_q_r && enable && !busy;

    always_ff @(posedge clock) begin
        if (sys_rst)
            trig_q_r <= 1'b0;
        else
            trig_q_r <= trigger;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            busy <= 1'b0;
            count_r <= 16'h0000;
        end else if (start) begin
            busy <= 1'b1;
            count_r <= 16'(CYCLES - 1);
        end else if (busy) begin
            if (count_r == 16'h0000)
                busy <= 1'b0;
            else
                count_r <= count_r - 16'h0001;
        end
    end
endmodule : cal_sequencer

// ---- src/bank_config_regs.sv ----
// per-bank configuration registers for sixteen line channels
// assumes an ahb-lite master on the same clock; per-channel settings,
// loss of signal and line data come from same-clock logic
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
// Functional notes
// - upper monitor field: low bits zero disable; top bit picks rx/tx
// - loopback bit loops system transmit data back to system receive
// - attenuator may sit in transmit or receive path during loopback
// - criteria bit picks ETS or G.775 in E1; T1/J1 uses T1.231
// - all-ones bit plus loss of signal sends all ones from master clock
// - calibrate trigger serves all sixteen channels; other bits lower only
// - match mode set means fully internal; clear means trimmed resistor
// - bank alarm-on-loss bit forces alarm upon loss for whole bank
// - bank protect-disable bit turns protection off bank-wide
// - bank code bit forces AMI coding over per-channel setting
// - bank depth bit forces 128-bit attenuator depth
// - rising trigger starts calibration only with upper enable set
// - lower position bit; per-channel ignored when bank enable set
// - upper position bit set forces receive path for every upper-bank channel
// - bank enable bit forces attenuator on over per-channel setting
// - receive match bit on enables matching; off leaves inputs high-z
module bank_config_regs
    import bank_cfg_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CAL_LEN = CAL_CYCLES
)(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [3:0] monitor_select,
    input wire logic [15:0] e1_mode,
    input wire logic [15:0] los,
    input wire logic [15:0] chan_alarm_on_loss,
    input wire logic [15:0] chan_protect_disable,
    input wire logic [15:0] chan_line_code,
    input wire logic [15:0] chan_attenuator_depth,
    input wire logic [15:0] chan_attenuator_position,
    input wire logic [15:0] chan_attenuator_enable,
    input wire logic [15:0] rx_match_on,
    input wire logic [15:0] sys_tx_positive,
    input wire logic [15:0] sys_tx_negative,
    input wire logic [15:0] line_rx_positive,
    input wire logic [15:0] line_rx_negative,
    output logic [15:0] sys_rx_positive_r,
    output logic [15:0] sys_rx_negative_r,
    output logic [15:0] loopback_on_r,
    output logic [15:0] criteria_ets_r,
    output logic [15:0] criteria_t1_r,
    output logic [15:0] send_all_ones_r,
    output logic [15:0] alarm_to_sys_r,
    output logic [15:0] protect_off_r,
    output logic [15:0] ami_code_r,
    output logic [15:0] depth_128_r,
    output logic [15:0] att_rx_path_r,
    output logic [15:0] att_enable_r,
    output logic [15:0] rx_full_internal_r,
    output logic [15:0] rx_ext_trim_r,
    output logic [15:0] rx_high_z_r,
    output logic monitor_on_r,
    output logic monitor_tx_r,
    output logic [4:0] monitor_chan_r,
    output logic cal_busy_r,
    output logic rx_level_status_r
);
    import bank_cfg_pkg::*;

    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
        $error("bank_config_regs: ADDR_W out of range");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // map a word index onto a register slot {bank, sel}
    function automatic logic [3:0] decode(input logic [5:0] idx);
        logic hit;
        hit = (idx[4:0] == LOOPBACK_CTRL_LOWER_IDX[4:0])
            || (idx[4:0] == LOSS_CRITERIA_LOWER_IDX[4:0])
            || (idx[4:0] == AUTO_ALL_ONES_LOWER_IDX[4:0])
            || (idx[4:0] == GLOBAL_CONFIG_LOWER_IDX[4:0]);
        decode = {hit, idx[5], idx[1:0]};
    endfunction : decode

    // a set bank bit overrides that bank's per-channel bits
    function automatic logic [15:0] force_bank(input logic lower_bit,
        input logic upper_bit, input logic [15:0] chan);
        force_bank[7:0] = lower_bit ? 8'hff : chan[7:0];
        force_bank[15:8] = upper_bit ? 8'hff : chan[15:8];
    endfunction : force_bank

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic [7:0] regs_r [NUM_REGS];
    logic [3:0] addr_dec;
    logic take;
    logic wr_pend_r;
    logic [2:0] wr_slot_r;
    logic [7:0] rd_byte;

    assign addr_dec = decode(haddr[7:2]);
    assign take = hsel && htrans[1] && hready;

    // writes land at the end of the data phase
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_pend_r <= 1'b0;
            wr_slot_r <= 3'h0;
        end else begin
            wr_pend_r <= take && hwrite && addr_dec[3];
            wr_slot_r <= addr_dec[2:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_REGS; i++)
                regs_r[i] <= REG_RESET;
        end else if (wr_pend_r) begin
            regs_r[wr_slot_r] <= hwdata[7:0];
        end
    end

    // read data is captured in the address phase; a write finishing in
    // that same edge is forwarded so back-to-back access reads fresh
    always_comb begin
        rd_byte = 8'h00;
        if (addr_dec[3]) begin
            if (wr_pend_r && wr_slot_r == addr_dec[2:0])
                rd_byte = hwdata[7:0];
            else
                rd_byte = regs_r[addr_dec[2:0]];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
            hrdata <= {24'h00_0000, rd_byte};
    end

    // zero wait states, always OKAY; same value in and out of reset
    always_ff @(posedge clock) begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end

    // ------------------------------------------------------------
    // register fields
    // ------------------------------------------------------------
    logic [15:0] loop_bits;
    logic [15:0] crit_bits;
    logic [15:0] ones_bits;
    logic [7:0] gc_lo;
    logic [7:0] gc_up;
    logic [15:0] pos_nxt;

    assign loop_bits = {regs_r[{1'b1, SEL_LOOPBACK}],
                        regs_r[{1'b0, SEL_LOOPBACK}]};
    assign crit_bits = {regs_r[{1'b1, SEL_CRITERIA}],
                        regs_r[{1'b0, SEL_CRITERIA}]};
    assign ones_bits = {regs_r[{1'b1, SEL_ALL_ONES}],
                        regs_r[{1'b0, SEL_ALL_ONES}]};
    assign gc_lo = regs_r[{1'b0, SEL_GLOBAL}];
    assign gc_up = regs_r[{1'b1, SEL_GLOBAL}];

    // ------------------------------------------------------------
    // loopback and per-channel line behaviour
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            loopback_on_r <= 16'h0000;
            sys_rx_positive_r <= 16'h0000;
            sys_rx_negative_r <= 16'h0000;
        end else begin
            loopback_on_r <= loop_bits;
            // looped data takes the encoder/decoder path, modelled
            // here as a one-cycle register stage
            sys_rx_positive_r <= (sys_tx_positive & loop_bits)
                | (line_rx_positive & ~loop_bits);
            sys_rx_negative_r <= (sys_tx_negative & loop_bits)
                | (line_rx_negative & ~loop_bits);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            criteria_ets_r <= 16'h0000;
            criteria_t1_r <= 16'h0000;
            send_all_ones_r <= 16'h0000;
        end else begin
            // T1/J1 ignores the bit; clear bit in E1 means G.775
            criteria_ets_r <= crit_bits & e1_mode;
            criteria_t1_r <= ~e1_mode;
            // pattern generator downstream runs from the master clock
            send_all_ones_r <= ones_bits & los;
        end
    end

    // ------------------------------------------------------------
    // bank-wide overrides; lower global bits touch channels 1-8 only
    // ------------------------------------------------------------
    always_comb begin
        // lower: bank enable hands position to the bank bit
        pos_nxt[7:0] = gc_lo[GC_ATT_ENABLE] ?
            {BANK_CHANS{gc_lo[GC_ATT_POSITION]}} :
            chan_attenuator_position[7:0];
        pos_nxt[15:8] = gc_up[GC_ATT_POSITION] ?
            8'hff : chan_attenuator_position[15:8];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            alarm_to_sys_r <= 16'h0000;
            protect_off_r <= 16'h0000;
            ami_code_r <= 16'h0000;
            depth_128_r <= 16'h0000;
            att_rx_path_r <= 16'h0000;
            att_enable_r <= 16'h0000;
        end else begin
            alarm_to_sys_r <= los & force_bank(gc_lo[GC_ALARM_ON_LOSS],
                gc_up[GC_ALARM_ON_LOSS], chan_alarm_on_loss);
            protect_off_r <= force_bank(gc_lo[GC_PROTECT_DISABLE],
                gc_up[GC_PROTECT_DISABLE], chan_protect_disable);
            ami_code_r <= force_bank(gc_lo[GC_LINE_CODE],
                gc_up[GC_LINE_CODE], chan_line_code);
            depth_128_r <= force_bank(gc_lo[GC_ATT_DEPTH],
                gc_up[GC_ATT_DEPTH], chan_attenuator_depth);
            // position holds in loopback too, so either path works
            att_rx_path_r <= pos_nxt;
            att_enable_r <= force_bank(gc_lo[GC_ATT_ENABLE],
                gc_up[GC_ATT_ENABLE], chan_attenuator_enable);
        end
    end

    // ------------------------------------------------------------
    // receive termination
    // ------------------------------------------------------------
    logic [15:0] mode_v;

    assign mode_v = {{BANK_CHANS{gc_up[GC_RX_MATCH_MODE]}},
                     {BANK_CHANS{gc_lo[GC_RX_MATCH_MODE]}}};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_full_internal_r <= 16'h0000;
            rx_ext_trim_r <= 16'h0000;
            rx_high_z_r <= 16'h0000;
        end else begin
            rx_full_internal_r <= rx_match_on & mode_v;
            rx_ext_trim_r <= rx_match_on & ~mode_v;
            rx_high_z_r <= ~rx_match_on;
        end
    end

    // ------------------------------------------------------------
    // monitor select and calibration
    // ------------------------------------------------------------
    logic mon_on;
    logic mon_tx;
    logic [4:0] mon_chan;
    logic cal_busy;

    monitor_decode u_monitor (
        .monitor_select(monitor_select),
        .monitor_on(mon_on),
        .monitor_tx(mon_tx),
        .monitor_chan(mon_chan)
    );

    // one engine for all sixteen channels, keyed by the lower trigger
    cal_sequencer #(.CYCLES(CAL_LEN)) u_cal (
        .clock(clock),
        .sys_rst(sys_rst),
        .trigger(gc_lo[GC_CALIBRATE]),
        .enable(gc_up[GC_CALIBRATE]),
        .busy(cal_busy)
    );

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            monitor_on_r <= 1'b0;
            monitor_tx_r <= 1'b0;
            monitor_chan_r <= 5'h00;
            cal_busy_r <= 1'b0;
            rx_level_status_r <= 1'b0;
        end else begin
            monitor_on_r <= mon_on;
            monitor_tx_r <= mon_tx;
            monitor_chan_r <= mon_chan;
            cal_busy_r <= cal_busy;
            // progress is only visible while the trigger stays set
            rx_level_status_r <= cal_busy && gc_lo[GC_CALIBRATE];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_cal_rise;
        !gc_lo[GC_CALIBRATE] ##1 gc_lo[GC_CALIBRATE] && !cal_busy;
    endsequence

    chk_monitor_decode: assert property (
        monitor_select[2:0] != 3'h0 |=> monitor_on_r
            && monitor_chan_r == 5'($past(monitor_select[2:0]) + 4'h9))
        else $error("monitor channel decode wrong");
    chk_monitor_off: assert property (
        monitor_select[2:0] == 3'h0 |=> !monitor_on_r)
        else $error("monitor not disabled");
    chk_write_readback: assert property (
        wr_pend_r |=> regs_r[$past(wr_slot_r)] == $past(hwdata[7:0]))
        else $error("register write lost");
    chk_loop_data: assert property (
        loop_bits[0] && $stable(loop_bits[0])
            |=> sys_rx_positive_r[0] == $past(sys_tx_positive[0]))
        else $error("loopback data not returned");
    chk_all_ones_los: assert property (
        ones_bits[9] && los[9] |=> send_all_ones_r[9])
        else $error("all ones not sent on loss");
    chk_alarm_force: assert property (
        gc_lo[GC_ALARM_ON_LOSS] && los[3] |=> alarm_to_sys_r[3])
        else $error("bank alarm not forced");
    chk_lower_scope: assert property (
        !gc_up[GC_PROTECT_DISABLE] && !chan_protect_disable[12]
            |=> !protect_off_r[12])
        else $error("lower bank bit leaked upward");
    chk_code_depth: assert property (
        gc_up[GC_LINE_CODE] && gc_up[GC_ATT_DEPTH]
            |=> ami_code_r[15:8] == 8'hff && depth_128_r[15:8] == 8'hff)
        else $error("bank code or depth not forced");
    chk_position_lower: assert property (
        gc_lo[GC_ATT_ENABLE] && !gc_lo[GC_ATT_POSITION]
            |=> att_rx_path_r[7:0] == 8'h00 && att_enable_r[7:0] == 8'hff)
        else $error("lower position override wrong");
    chk_position_upper: assert property (
        gc_up[GC_ATT_POSITION] |=> att_rx_path_r[15:8] == 8'hff)
        else $error("upper position override wrong");
    chk_cal_start: assert property (
        s_cal_rise ##0 gc_up[GC_CALIBRATE] |=> cal_busy [*8])
        else $error("calibration did not run");
    chk_cal_blocked: assert property (
        s_cal_rise ##0 !gc_up[GC_CALIBRATE] |=> !cal_busy)
        else $error("calibration ran without enable");
    chk_rx_match: assert property (
        rx_match_on[1] && !gc_lo[GC_RX_MATCH_MODE]
            |=> rx_ext_trim_r[1] && !rx_full_internal_r[1])
        else $error("receive match mode wrong");
endmodule : bank_config_regs

// ---- test/tb_bank_config_regs.sv ----
// self-checking bench for the per-bank configuration register block
// assumes zero-wait ahb-lite answers and one-cycle registered outputs
`timescale 1ns/1ps
module tb_bank_config_regs;
    import bank_cfg_pkg::*;
    typedef struct {int sel; logic [31:0] v;} note_s;
    localparam int CAL = 16;
    logic clock, sys_rst, hsel, hwrite, hreadyout, hresp, probe, rd_ph;
    logic mon_on, mon_tx, busy, lvl;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [3:0] msel;
    logic [4:0] mon_ch;
    logic [15:0] x [13];
    logic [15:0] y [1:15];
    logic [7:0] m [8];
    note_s q [$];
    int mismatches, comparisons;

    // short cal length keeps the run brief
    bank_config_regs #(.CAL_LEN(CAL)) uut (
        .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .monitor_select(msel), .e1_mode(x[0]),
        .los(x[1]), .chan_alarm_on_loss(x[2]),
        .chan_protect_disable(x[3]), .chan_line_code(x[4]),
        .chan_attenuator_depth(x[5]), .chan_attenuator_position(x[6]),
        .chan_attenuator_enable(x[7]), .rx_match_on(x[8]),
        .sys_tx_positive(x[9]), .sys_tx_negative(x[10]),
        .line_rx_positive(x[11]), .line_rx_negative(x[12]),
        .sys_rx_positive_r(y[1]), .sys_rx_negative_r(y[2]),
        .loopback_on_r(y[3]), .criteria_ets_r(y[4]), .criteria_t1_r(y[5]),
        .send_all_ones_r(y[6]), .alarm_to_sys_r(y[7]),
        .protect_off_r(y[8]), .ami_code_r(y[9]), .depth_128_r(y[10]),
        .att_rx_path_r(y[11]), .att_enable_r(y[12]),
        .rx_full_internal_r(y[13]), .rx_ext_trim_r(y[14]),
        .rx_high_z_r(y[15]), .monitor_on_r(mon_on), .monitor_tx_r(mon_tx),
        .monitor_chan_r(mon_ch), .cal_busy_r(busy), .rx_level_status_r(lvl)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // expectations and comparison
    // ------------------------------------------------------------
    function automatic logic [15:0] bb(int f);
        return {{8{m[7][f]}}, {8{m[3][f]}}};
    endfunction : bb

    function automatic logic [15:0] want(int s);
        logic [15:0] lb;
        lb = {m[4], m[0]};
        case (s)
            1: return (lb & x[9]) | (~lb & x[11]);
            2: return (lb & x[10]) | (~lb & x[12]);
            3: return lb;
            4: return {m[5], m[1]} & x[0];
            5: return ~x[0];
            6: return {m[6], m[2]} & x[1];
            7: return x[1] & (bb(6) | x[2]);
            8: return bb(5) | x[3];
            9: return bb(4) | x[4];
            10: return bb(3) | x[5];
            11: return {m[7][1] ? 8'hff : x[6][15:8],
                m[3][0] ? {8{m[3][1]}} : x[6][7:0]};
            12: return bb(0) | x[7];
            13: return x[8] & bb(7);
            14: return x[8] & ~bb(7);
            default: return ~x[8];
        endcase
    endfunction : want

    function automatic logic [31:0] pick(int s);
        if (s == 16) return {26'h0, mon_on, mon_ch};
        if (s == 17) return {30'h0, busy, lvl};
        if (s == 18) return {31'h0, mon_tx};
        return {16'h0, y[s]};
    endfunction : pick

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic note(int s, logic [31:0] v);
        q.push_back('{s, v});
    endtask : note

    // oldest note first; probe drains the output notes
    always @(posedge clock) begin
        note_s n;
        if (rd_ph) begin
            n = q.pop_front();
            check(hrdata, n.v);
            check({31'h0, hresp}, 32'h0);
        end
        while (probe && q.size() > 0) begin
            n = q.pop_front();
            check(pick(n.sel), n.v);
        end
        rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
    end

    task close_out;
        $display("counts: %0d compared, %0d bad", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // bus master
    // ------------------------------------------------------------
    task wt;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            close_out();
        end
    endtask : wt

    task automatic aph(logic [7:0] a, logic w);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wt();
        htrans <= 2'h0;
    endtask : aph

    task automatic wr(logic [7:0] a, logic [31:0] d);
        aph(a, 1'b1);
        hwdata <= d;
        wt();
    endtask : wr

    task automatic rd(logic [7:0] a, logic [31:0] e);
        note(0, e);
        aph(a, 1'b0);
        wt();
    endtask : rd

    task poke;
        probe <= 1'b1;
        @(posedge clock);
        probe <= 1'b0;
        @(posedge clock);
    endtask : poke

    function automatic logic [7:0] ad(int i);
        logic [5:0] ix;
        ix = (i < 4) ? LOOPBACK_CTRL_LOWER_IDX : LOOPBACK_CTRL_UPPER_IDX;
        return {ix + 6'(i % 4), 2'b00};
    endfunction : ad

    // calibrate bit masked so random writes never start a cycle
    function automatic logic [7:0] rnd(int i);
        return 8'($urandom) & ((i % 4 == 3) ? 8'hfb : 8'hff);
    endfunction : rnd

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        hsel = 1'b1;
        hwrite = 1'b0;
        hsize = 3'h2;
        haddr = 8'h00;
        htrans = 2'h0;
        hwdata = 32'h0;
        msel = 4'h0;
        probe = 1'b0;
        rd_ph = 1'b0;
        foreach (x[k]) x[k] = 16'h0;
        void'($urandom(62826));
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        wr(8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
        for (int i = 0; i < 8; i++) begin
            m[i] = 8'h00;
            rd(ad(i), 32'h0);
        end
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            m[i] = rnd(i);
            wr(ad(i), {24'($urandom), m[i]});
            rd(ad(i), {24'h0, m[i]});
        end
        $display("test readback done");
        repeat (8) begin
            foreach (x[k]) x[k] <= 16'($urandom);
            for (int i = 0; i < 8; i++) begin
                m[i] = rnd(i);
                wr(ad(i), {24'h0, m[i]});
            end
            repeat (2) @(posedge clock);
            for (int s = 1; s < 16; s++) note(s, {16'h0, want(s)});
            poke();
        end
        $display("test overrides done");
        for (int v = 0; v < 16; v++) begin
            msel <= 4'(v);
            repeat (2) @(posedge clock);
            note(16, (v % 8) ? {27'h1, 5'(9 + v % 8)} : 32'h0);
            if (v % 8) note(18, {31'h0, v[3]});
            poke();
        end
        $display("test monitor decode done");
        wr(ad(7), 32'h0);
        wr(ad(3), 32'h0);
        wr(ad(3), 32'h4);
        repeat (3) @(posedge clock);
        note(17, 32'h0);
        poke();
        wr(ad(3), 32'h0);
        wr(ad(7), 32'h4);
        repeat (500) @(posedge clock);
        wr(ad(3), 32'h4);
        repeat (3) @(posedge clock);
        note(17, 32'h3);
        poke();
        repeat (CAL + 4) @(posedge clock);
        note(17, 32'h0);
        poke();
        $display("test calibration done");
        close_out();
    end
endmodule : tb_bank_config_regs
